/* File: rtl/mtc_timer.sv */
// Six-channel timer: clock select, clearing, capture, compare and AXI4-Lite registers
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// Operation
// - Channels 1, 5 phase inputs on pins A, B
// - Channels 2, 4 phase inputs on pins C, D
// - One two-way pin per general register
// - Four registers on channels 0, 3; else two
// - Six control registers, one per channel
// - Bits 7..5 pick counter clear source
// - Bits 4..3 pick edge, 00 rising
// - Both edges count at double rate
// - Phase counting overrides edge select
// - Edge select ignored for undivided clock
// - 01 falling edge, 1x both edges
// - Four-register clear codes include C, D
// - Bit 7 reserved on two-register channels
module mtc_timer (
  input  wire logic                          clk,           // System clock
  input  wire logic                          rst,           // Async reset, active high
  input  wire logic [mtc_pkg::ADDR_W-1:0]    s_axi_awaddr,  // Write address
  input  wire logic                          s_axi_awvalid, // Write address valid
  output logic                               s_axi_awready, // Write address ready
  input  wire logic [31:0]                   s_axi_wdata,   // Write data
  input  wire logic [3:0]                    s_axi_wstrb,   // Write byte strobes
  input  wire logic                          s_axi_wvalid,  // Write data valid
  output logic                               s_axi_wready,  // Write data ready
  output logic [1:0]                         s_axi_bresp,   // Write response
  output logic                               s_axi_bvalid,  // Write response valid
  input  wire logic                          s_axi_bready,  // Write response ready
  input  wire logic [mtc_pkg::ADDR_W-1:0]    s_axi_araddr,  // Read address
  input  wire logic                          s_axi_arvalid, // Read address valid
  output logic                               s_axi_arready, // Read address ready
  output logic [31:0]                        s_axi_rdata,   // Read data
  output logic [1:0]                         s_axi_rresp,   // Read response
  output logic                               s_axi_rvalid,  // Read data valid
  input  wire logic                          s_axi_rready,  // Read data ready
  input  wire logic [mtc_pkg::NUM_EXT-1:0]   extClkPin,     // External clock pins A..D
  input  wire logic [mtc_pkg::NUM_PIN-1:0]   ioPinIn,       // Pin levels, index ch*4+reg
  output logic [mtc_pkg::NUM_PIN-1:0]        ioPinOut,      // Pin drive values
  output logic [mtc_pkg::NUM_PIN-1:0]        ioPinOe        // Pin output enables
);
  import mtc_pkg::*;

  // Register storage, one element per channel
  logic [7:0]       ctrlR [NUM_CH];
  logic [7:0]       modeR [NUM_CH];
  logic [7:0]       ioHR  [NUM_CH];
  logic [7:0]       ioLR  [NUM_CH];
  logic [CNT_W-1:0] cntR  [NUM_CH];
  logic [CNT_W-1:0] grR   [NUM_CH][NUM_REG];
  logic [NUM_CH-1:0] runR;
  logic [NUM_CH-1:0] syncR;
  logic [NUM_CH-1:0] chClr;

  // Bus state
  logic [ADDR_W-1:0] wAddrQ;
  logic [31:0]       wDataQ;
  logic [3:0]        wStrbQ;
  logic              awHeld;
  logic              wHeld;
  logic              doWrite;
  logic              wrOk;
  logic [31:0]       rdNext;

  // Synchronisers and prescaler
  logic [NUM_EXT-1:0] extS1, extS2, extS3;
  logic [NUM_PIN-1:0] pinS1, pinS2, pinS3;
  logic [NUM_EXT-1:0] extRise, extFall;
  logic [NUM_PIN-1:0] pinRise, pinFall;
  logic [PSC_W-1:0]   psc, pscPrev;
  logic [PSC_W-1:0]   pscRise, pscFall;

  // Decodes whether a byte address holds a register
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [2:0] ch;
    logic [5:0] off;
    logic       four;
    ch   = a[8:6];
    off  = a[5:0];
    four = (ch == 3'h0) || (ch == 3'h3);
    mapped = (a == ADDR_RUN) || (a == ADDR_SYNC) ||
             ((ch < 3'(NUM_CH)) &&
              (off == OFF_CTRL || off == OFF_MODE || off == OFF_IOH ||
               off == OFF_CNT || off == OFF_GRA || off == OFF_GRB ||
               (four && (off == OFF_IOL || off == OFF_GRC || off == OFF_GRD))));
  endfunction

  // Matches a channel register address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input int ch, input logic [5:0] off);
    hit = (a[8:6] == 3'(ch)) && (a[5:0] == off);
  endfunction

  // Merges written byte lanes into the old value
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction

  // Offset of general register r
  function automatic logic [5:0] grOff(input int r);
    grOff = OFF_GRA + 6'(4 * r);
  endfunction

  // Two flops per pin; the third only feeds edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extS1 <= '0;
      extS2 <= '0;
      extS3 <= '0;
      pinS1 <= '0;
      pinS2 <= '0;
      pinS3 <= '0;
    end else begin
      extS1 <= extClkPin;
      extS2 <= extS1;
      extS3 <= extS2;
      pinS1 <= ioPinIn;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
    end
  end

  // Single-cycle edge pulses in the system domain
  assign extRise = extS2 & ~extS3;
  assign extFall = ~extS2 & extS3;
  assign pinRise = pinS2 & ~pinS3;
  assign pinFall = ~pinS2 & pinS3;

  // Free-running prescaler shared by all channels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psc     <= '0;
      pscPrev <= '0;
    end else begin
      psc     <= psc + 1'b1;
      pscPrev <= psc;
    end
  end

  assign pscRise = psc & ~pscPrev;
  assign pscFall = ~psc & pscPrev;

  // Write address and data are taken in either order
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      awHeld        <= 1'b0;
      wAddrQ        <= '0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      s_axi_awready <= 1'b0;
      awHeld        <= 1'b1;
      wAddrQ        <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld        <= 1'b0;
    end else if (!awHeld && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
      wHeld        <= 1'b0;
      wDataQ       <= '0;
      wStrbQ       <= '0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      s_axi_wready <= 1'b0;
      wHeld        <= 1'b1;
      wDataQ       <= s_axi_wdata;
      wStrbQ       <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld        <= 1'b0;
    end else if (!wHeld && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Unmapped writes are dropped and answered with an error
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign wrOk    = doWrite && mapped(wAddrQ);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(wAddrQ) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux; absent registers read as zero
  always_comb begin
    rdNext = '0;
    if (s_axi_araddr == ADDR_RUN) begin
      rdNext = 32'(runR);
    end else if (s_axi_araddr == ADDR_SYNC) begin
      rdNext = 32'(syncR);
    end else if (mapped(s_axi_araddr)) begin
      unique case (s_axi_araddr[5:0])
        OFF_CTRL: rdNext = 32'(ctrlR[s_axi_araddr[8:6]]);
        OFF_MODE: rdNext = 32'(modeR[s_axi_araddr[8:6]]);
        OFF_IOH:  rdNext = 32'(ioHR[s_axi_araddr[8:6]]);
        OFF_IOL:  rdNext = 32'(ioLR[s_axi_araddr[8:6]]);
        OFF_CNT:  rdNext = 32'(cntR[s_axi_araddr[8:6]]);
        OFF_GRA:  rdNext = 32'(grR[s_axi_araddr[8:6]][0]);
        OFF_GRB:  rdNext = 32'(grR[s_axi_araddr[8:6]][1]);
        OFF_GRC:  rdNext = 32'(grR[s_axi_araddr[8:6]][2]);
        OFF_GRD:  rdNext = 32'(grR[s_axi_araddr[8:6]][3]);
        default:  rdNext = '0;
      endcase
    end
  end

  // Read answers one cycle after the address is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdNext;
      s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Common run and synchronous-clear enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      runR  <= '0;
      syncR <= '0;
    end else if (wrOk && wAddrQ == ADDR_RUN) begin
      runR  <= NUM_CH'(merge(32'(runR), wDataQ, wStrbQ));
    end else if (wrOk && wAddrQ == ADDR_SYNC) begin
      syncR <= NUM_CH'(merge(32'(syncR), wDataQ, wStrbQ));
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : gCh
    localparam bit FOUR = (c == 0) || (c == 3);
    localparam int NREG = FOUR ? 4 : 2;
    localparam int PA   = (c == 1 || c == 5) ? 0 : 2;
    localparam logic [NUM_CH-1:0] SELF = NUM_CH'(1) << c;
    mtc_ctrl_s        cs;
    logic             rise, fall, tick;
    logic             phOn, aEdge, bEdge, up;
    logic             ownClr, clrEvt;
    logic [NUM_REG-1:0] evt;
    logic [15:0]      ioCat;

    assign cs    = mtc_ctrl_s'(ctrlR[c]);
    assign ioCat = {ioLR[c], ioHR[c]};

    // Source select; undivided clock counts every cycle whatever the edge
    always_comb begin
      rise = 1'b0;
      fall = 1'b0;
      if (cs.prescale[2]) begin
        rise = extRise[cs.prescale[1:0]];
        fall = extFall[cs.prescale[1:0]];
      end else begin
        unique case (cs.prescale[1:0])
          2'h0: begin
            rise = 1'b1;
            fall = 1'b1;
          end
          2'h1: begin
            rise = pscRise[TAP4];
            fall = pscFall[TAP4];
          end
          2'h2: begin
            rise = pscRise[TAP16];
            fall = pscFall[TAP16];
          end
          2'h3: begin
            rise = pscRise[TAP64];
            fall = pscFall[TAP64];
          end
        endcase
      end
    end

    // Edge qualification of the selected source
    assign tick = cs.edgeSel[1] ? (rise | fall) :
                  (cs.edgeSel == EDGE_FALL) ? fall : rise;

    // Quadrature decode from the channel's pin pair
    assign phOn  = !FOUR && modeR[c][MODE_PHASE];
    assign aEdge = extRise[PA] | extFall[PA];
    assign bEdge = extRise[PA+1] | extFall[PA+1];
    assign up    = aEdge ? (extS2[PA] != extS2[PA+1]) : (extS2[PA] == extS2[PA+1]);

    // Clear source decode; C and D exist only on four-register channels
    always_comb begin
      unique case (cs.clrSrc)
        CLR_A:   ownClr = evt[0];
        CLR_B:   ownClr = evt[1];
        CLR_C:   ownClr = FOUR && evt[2];
        CLR_D:   ownClr = FOUR && evt[3];
        default: ownClr = 1'b0;
      endcase
    end

    assign chClr[c] = ownClr;
    assign clrEvt   = ownClr || ((cs.clrSrc[1:0] == CLR_SYNC_LO) && syncR[c] &&
                      |(chClr & syncR & ~SELF));

    // Counter: software write, then clear, then counting
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cntR[c] <= '0;
      end else if (wrOk && hit(wAddrQ, c, OFF_CNT)) begin
        cntR[c] <= CNT_W'(merge(32'(cntR[c]), wDataQ, wStrbQ));
      end else if (clrEvt) begin
        cntR[c] <= '0;
      end else if (runR[c] && phOn) begin
        if (aEdge || bEdge) begin
          cntR[c] <= up ? cntR[c] + 1'b1 : cntR[c] - 1'b1;
        end
      end else if (runR[c] && tick) begin
        cntR[c] <= cntR[c] + 1'b1;
      end
    end

    // Control, mode and pin function registers of this channel only
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ctrlR[c] <= CTRL_RST;
        modeR[c] <= '0;
        ioHR[c]  <= '0;
        ioLR[c]  <= '0;
      end else if (wrOk && wStrbQ[0]) begin
        if (hit(wAddrQ, c, OFF_CTRL)) begin
          ctrlR[c] <= FOUR ? wDataQ[7:0] : (wDataQ[7:0] & CTRL_MASK);
        end
        if (hit(wAddrQ, c, OFF_MODE)) begin
          modeR[c] <= {7'h00, !FOUR && wDataQ[MODE_PHASE]};
        end
        if (hit(wAddrQ, c, OFF_IOH)) begin
          ioHR[c] <= {4'h0, wDataQ[3:0]};
        end
        if (hit(wAddrQ, c, OFF_IOL)) begin
          ioLR[c] <= {4'h0, wDataQ[3:0]};
        end
      end
    end

    for (genvar r = 0; r < NUM_REG; r++) begin : gReg
      localparam int PIN = c * NUM_REG + r;
      logic [1:0] io;
      logic       eqPrev, cmpEvt, capEvt, outQ, oeQ;

      assign io     = ioCat[2*r +: 2];
      assign cmpEvt = (r < NREG) && !io[1] && (cntR[c] == grR[c][r]) && !eqPrev;
      assign capEvt = (r < NREG) && (((io == IO_CAP_RISE) && pinRise[PIN]) ||
                      ((io == IO_CAP_FALL) && pinFall[PIN]));
      assign evt[r] = cmpEvt || capEvt;

      // Match is an event only on entry into equality
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          eqPrev <= 1'b0;
        end else begin
          eqPrev <= (cntR[c] == grR[c][r]);
        end
      end

      // Capture beats a software write in the same cycle
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          grR[c][r] <= '0;
        end else if (capEvt) begin
          grR[c][r] <= cntR[c];
        end else if (wrOk && hit(wAddrQ, c, grOff(r))) begin
          grR[c][r] <= CNT_W'(merge(32'(grR[c][r]), wDataQ, wStrbQ));
        end
      end

      // Pin drives only while the register compares with toggle output
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          outQ <= 1'b0;
          oeQ  <= 1'b0;
        end else begin
          oeQ <= (r < NREG) && (io == IO_TOGGLE);
          if (cmpEvt && io == IO_TOGGLE) begin
            outQ <= !outQ;
          end
        end
      end

      assign ioPinOut[PIN] = outQ;
      assign ioPinOe[PIN]  = oeQ;
    end
  end

endmodule // mtc_timer

/* File: common/mtc_pkg.sv */
// Shared constants, field layouts and types of the six-channel timer
package mtc_pkg;
  // Structure
  localparam int NUM_CH  = 6;
  localparam int CNT_W   = 16;
  localparam int NUM_REG = 4;
  localparam int NUM_PIN = NUM_CH * NUM_REG;
  localparam int NUM_EXT = 4;
  localparam int ADDR_W  = 9;
  // Per-channel word offsets inside a 64-byte channel window
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_MODE = 6'h04;
  localparam logic [5:0] OFF_IOH  = 6'h08;
  localparam logic [5:0] OFF_IOL  = 6'h0C;
  localparam logic [5:0] OFF_CNT  = 6'h10;
  localparam logic [5:0] OFF_GRA  = 6'h20;
  localparam logic [5:0] OFF_GRB  = 6'h24;
  localparam logic [5:0] OFF_GRC  = 6'h28;
  localparam logic [5:0] OFF_GRD  = 6'h2C;
  // Common registers
  localparam logic [ADDR_W-1:0] ADDR_RUN  = 9'h180;
  localparam logic [ADDR_W-1:0] ADDR_SYNC = 9'h184;
  // Reset values and masks
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h7F;
  localparam int         MODE_PHASE = 0;
  // Clock edge codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  // Clear source codes
  localparam logic [2:0] CLR_A = 3'h1;
  localparam logic [2:0] CLR_B = 3'h2;
  localparam logic [2:0] CLR_C = 3'h5;
  localparam logic [2:0] CLR_D = 3'h6;
  localparam logic [1:0] CLR_SYNC_LO = 2'h3;
  // Prescaler taps: divide by 4, 16, 64
  localparam int PSC_W   = 6;
  localparam int TAP4    = 1;
  localparam int TAP16   = 3;
  localparam int TAP64   = 5;
  // Pin function codes, two bits per general register
  localparam logic [1:0] IO_TOGGLE   = 2'h1;
  localparam logic [1:0] IO_CAP_RISE = 2'h2;
  localparam logic [1:0] IO_CAP_FALL = 2'h3;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Counter control layout, bit 7 down to 0
  typedef struct packed {
    logic [2:0] clrSrc;
    logic [1:0] edgeSel;
    logic [2:0] prescale;
  } mtc_ctrl_s;
endpackage

/* File: tb/mtc_monitor.sv */
// Checker of bus timing, address map and pin drive of the timer
`timescale 1ns/1ps
module mtc_monitor
  import mtc_pkg::*;
(
  input wire logic               clk,           // Clock
  input wire logic               rst,           // Reset
  input wire logic [ADDR_W-1:0]  s_axi_awaddr,  // Write address
  input wire logic               s_axi_awvalid, // AW valid
  input wire logic               s_axi_awready, // AW ready
  input wire logic               s_axi_wvalid,  // W valid
  input wire logic               s_axi_wready,  // W ready
  input wire logic [1:0]         s_axi_bresp,   // B code
  input wire logic               s_axi_bvalid,  // B valid
  input wire logic               s_axi_bready,  // B ready
  input wire logic [ADDR_W-1:0]  s_axi_araddr,  // Read address
  input wire logic               s_axi_arvalid, // AR valid
  input wire logic               s_axi_arready, // AR ready
  input wire logic [31:0]        s_axi_rdata,   // Read data
  input wire logic [1:0]         s_axi_rresp,   // R code
  input wire logic               s_axi_rvalid,  // R valid
  input wire logic [NUM_PIN-1:0] ioPinOut,      // Pin values
  input wire logic [NUM_PIN-1:0] ioPinOe        // Pin enables
);
  logic [ADDR_W-1:0] awQ; // Address of the write under way
  logic [ADDR_W-1:0] arQ; // Address of the read under way

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Decoded map; C/D places exist only on the four-register channels
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    if (a[8:6] == 3'h6)
      return (a == ADDR_RUN) || (a == ADDR_SYNC);
    if (a[8:6] == 3'h7)
      return 1'b0;
    if (a[5:0] inside {OFF_IOL, OFF_GRC, OFF_GRD})
      return (a[8:6] == 3'h0) || (a[8:6] == 3'h3);
    return a[5:0] inside {OFF_CTRL, OFF_MODE, OFF_IOH, OFF_CNT, OFF_GRA, OFF_GRB};
  endfunction

  // Addresses kept until the answer, since the answer comes later
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      awQ <= '0;
    else if (s_axi_awvalid && s_axi_awready)
      awQ <= s_axi_awaddr;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      arQ <= '0;
    else if (s_axi_arvalid && s_axi_arready)
      arQ <= s_axi_araddr;
  end

  sequence sWrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sWrAnswer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  a_write_answer: assert property (sWrTaken |=> sWrAnswer)
    else $error("write answer not two edges after handshake");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_write_map: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (mapped(awQ) ? RESP_OKAY : RESP_SLVERR))
    else $error("write code wrong for address");
  a_read_map: assert property ($rose(s_axi_rvalid) |-> s_axi_rresp == (mapped(arQ) ? RESP_OKAY : RESP_SLVERR))
    else $error("read code wrong for address");
  a_ctrl_bit7: assert property ($rose(s_axi_rvalid) && (arQ[5:0] == OFF_CTRL) && (arQ[8:6] inside {3'h1, 3'h2, 3'h4, 3'h5}) |-> s_axi_rdata[7] == 1'b0)
    else $error("reserved control bit read as one");
  a_pin_unused: assert property ((ioPinOe & 24'hCC0CC0) == 24'h0)
    else $error("absent register pin driven");
  a_out_needs_oe: assert property (((ioPinOut ^ $past(ioPinOut)) & ~ioPinOe & ~$past(ioPinOe)) == 24'h0)
    else $error("pin value moved while not driven");
endmodule // mtc_monitor

bind mtc_timer mtc_monitor u_mon (
  .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .ioPinOut(ioPinOut), .ioPinOe(ioPinOe)
);

/* File: tb/mtc_pin_model.sv */
// Pulse sources, encoders and pin loads outside the timer
`timescale 1ns/1ps
module mtc_pin_model
  import mtc_pkg::*;
(
  input  wire logic [0:0]         clk,       // System clock
  input  wire logic [NUM_PIN-1:0] ioPinOut,  // Device drive values
  input  wire logic [NUM_PIN-1:0] ioPinOe,   // Device drive enables
  output logic      [NUM_EXT-1:0] extClkPin, // External clock pins
  output logic      [NUM_PIN-1:0] ioPinIn    // Resolved pin levels
);
  logic [NUM_PIN-1:0] capDrv; // Levels of the outside sources
  int                 gap = 2; // Cycles held after each level change; raise for a slow source

  initial begin
    extClkPin = '0;
    capDrv = '0;
  end

  // A driving device owns the wire, otherwise the outside source sets it
  assign ioPinIn = (ioPinOut & ioPinOe) | (capDrv & ~ioPinOe);

  // One level change just after an edge, then held
  task automatic ext(input int i, input logic v);
    @(posedge clk);
    extClkPin[i] <= v;
    repeat (gap) @(posedge clk);
  endtask
  task automatic cap(input int i, input logic v);
    @(posedge clk);
    capDrv[i] <= v;
    repeat (gap) @(posedge clk);
  endtask

  // One quadrature cycle on pair pr; A leads B when fwd
  task automatic quad(input int pr, input logic fwd);
    for (int k = 0; k < 4; k++)
      ext(2 * pr + int'(k[0] ^ !fwd), k < 2);
  endtask
endmodule // mtc_pin_model

/* File: tb/tb_multichannel_timer_clock_select.sv */
// Register-level test of the six-channel timer
`timescale 1ns/1ps
module tb_multichannel_timer_clock_select;
  import mtc_pkg::*;
  logic                clk;
  logic                rst;
  logic                awValid, awReady, wValid, wReady, bValid, bReady;
  logic                arValid, arReady, rValid, rReady;
  logic [ADDR_W-1:0]   awAddr, arAddr;
  logic [31:0]         wData, rData, got;
  logic [1:0]          bResp, rResp;
  logic [NUM_EXT-1:0]  extClkPin;
  logic [NUM_PIN-1:0]  ioPinIn, ioPinOut, ioPinOe;
  int                  n_errors, cmp_count, clrReg;
  localparam int       PH_CH [4] = '{1, 5, 2, 4};

  mtc_timer u_dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .extClkPin(extClkPin), .ioPinIn(ioPinIn), .ioPinOut(ioPinOut), .ioPinOe(ioPinOe)
  );
  mtc_pin_model u_pins (
    .clk(clk), .ioPinOut(ioPinOut), .ioPinOe(ioPinOe), .extClkPin(extClkPin), .ioPinIn(ioPinIn)
  );

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bounded wait for a handshake seen high at a rising edge
  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (s !== 1'b1 && k < 200);
    if (s !== 1'b1) begin
      n_errors++;
      $display("ERROR handshake expected 1 seen timeout");
      wrap_up();
    end
  endtask

  // Address and data offered together; each is released at its own ready
  task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [1:0] er);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    fork
      begin
        wait_hi(awReady);
        awValid <= 1'b0;
      end
      begin
        wait_hi(wReady);
        wValid <= 1'b0;
      end
    join
    bReady <= 1'b1;
    wait_hi(bValid);
    bReady <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bResp});
  endtask

  task automatic rd(input logic [8:0] a, input logic [1:0] er);
    arAddr <= a;
    arValid <= 1'b1;
    wait_hi(arReady);
    arValid <= 1'b0;
    rReady <= 1'b1;
    wait_hi(rValid);
    rReady <= 1'b0;
    got = rData;
    chk("rresp", {30'h0, er}, {30'h0, rResp});
  endtask

  task automatic rdc(input string nm, input logic [8:0] a, input logic [31:0] exp, input logic [1:0] er);
    rd(a, er);
    chk(nm, exp, got);
  endtask

  function automatic logic [8:0] adr(input int ch, input logic [5:0] o);
    return {ch[2:0], o};
  endfunction

  initial begin
    rst = 1'b1;
    {awValid, wValid, bReady, arValid, rReady} = '0;
    awAddr = '0;
    arAddr = '0;
    wData = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, then distinct words per channel
    for (int c = 0; c < NUM_CH; c++) rdc("ctrl reset", adr(c, OFF_CTRL), 32'h0, RESP_OKAY);
    for (int c = 0; c < NUM_CH; c++) wr(adr(c, OFF_CTRL), 32'(8'hE0 + c), RESP_OKAY);
    for (int c = 0; c < NUM_CH; c++)
      rdc("ctrl", adr(c, OFF_CTRL), 32'((c % 3 == 0) ? 8'hE0 + c : 8'h60 + c), RESP_OKAY);
    rdc("grc ch1", adr(1, OFF_GRC), 32'h0, RESP_SLVERR);
    wr(adr(2, OFF_GRD), 32'h55, RESP_SLVERR);
    rdc("iol ch4", adr(4, OFF_IOL), 32'h0, RESP_SLVERR);
    wr(adr(3, OFF_GRD), 32'hA5A5, RESP_OKAY);
    rdc("grd ch3", adr(3, OFF_GRD), 32'hA5A5, RESP_OKAY);
    // Pin A: three rises, two falls per pass; set up only while stopped
    for (int e = 0; e < 4; e++) begin
      wr(adr(0, OFF_CTRL), 32'(4 | (e << 3)), RESP_OKAY);
      wr(adr(0, OFF_CNT), 32'h0, RESP_OKAY);
      wr(ADDR_RUN, 32'h1, RESP_OKAY);
      for (int i = 0; i < 5; i++) u_pins.ext(0, !i[0]);
      repeat (8) @(posedge clk);
      wr(ADDR_RUN, 32'h0, RESP_OKAY);
      rdc("edge count", adr(0, OFF_CNT), 32'((e == 0) ? 3 : (e == 1) ? 2 : 5), RESP_OKAY);
      u_pins.ext(0, 1'b0);
    end
    // Slow encoders; both-edge and undivided settings must be ignored
    u_pins.gap = 6;
    foreach (PH_CH[j]) begin
      wr(adr(PH_CH[j], OFF_CTRL), 32'h10, RESP_OKAY);
      wr(adr(PH_CH[j], OFF_MODE), 32'h1, RESP_OKAY);
      wr(adr(PH_CH[j], OFF_CNT), 32'h0, RESP_OKAY);
    end
    wr(ADDR_RUN, 32'h36, RESP_OKAY);
    for (int s = 0; s < 3; s++) begin
      u_pins.quad(int'(s == 1), s != 2);
      foreach (PH_CH[j])
        rdc("phase", adr(PH_CH[j], OFF_CNT), 32'((j < 2) ? ((s < 2) ? 4 : 0) : ((s > 0) ? 4 : 0)), RESP_OKAY);
    end
    wr(ADDR_RUN, 32'h0, RESP_OKAY);
    // Every clear code on channel 0, compare A toggling its pin
    wr(adr(0, OFF_IOH), 32'h1, RESP_OKAY);
    @(posedge clk);
    chk("oe pin a", 32'h1, {31'h0, ioPinOe[0]});
    // Channel 3 clears on its compare A; sync codes on channel 0 follow it
    wr(ADDR_SYNC, 32'h9, RESP_OKAY);
    wr(adr(3, OFF_GRA), 32'h10, RESP_OKAY);
    wr(adr(3, OFF_CTRL), 32'h20, RESP_OKAY);
    for (int c = 0; c < 8; c++) begin
      clrReg = (c == 1) ? 0 : (c == 2) ? 1 : (c == 5) ? 2 : (c == 6) ? 3 : (c % 4 == 3) ? 4 : -1;
      for (int g = 0; g < 4; g++)
        wr(adr(0, OFF_GRA + 6'(4 * g)), (clrReg < 0 || clrReg == g) ? 32'h10 : 32'h8000, RESP_OKAY);
      wr(adr(0, OFF_CTRL), 32'(c << 5), RESP_OKAY);
      wr(adr(0, OFF_CNT), 32'h0, RESP_OKAY);
      wr(ADDR_RUN, 32'h9, RESP_OKAY);
      repeat (60) @(posedge clk);
      wr(ADDR_RUN, 32'h0, RESP_OKAY);
      rd(adr(0, OFF_CNT), RESP_OKAY);
      chk("cleared", {31'h0, clrReg >= 0}, {31'h0, got <= 32'h10});
      if (c == 0) chk("toggle pin a", 32'h1, {31'h0, ioPinOut[0]});
    end
    // Capture on rising edge of channel 3 pin A
    wr(adr(3, OFF_CTRL), 32'h0, RESP_OKAY);
    wr(adr(3, OFF_IOH), 32'h2, RESP_OKAY);
    wr(ADDR_RUN, 32'h8, RESP_OKAY);
    repeat (20) @(posedge clk);
    u_pins.cap(12, 1'b1);
    wr(ADDR_RUN, 32'h0, RESP_OKAY);
    rd(adr(3, OFF_GRA), RESP_OKAY);
    chk("capture", 32'h1, {31'h0, got != 32'h0});
    chk("oe capture pin", 32'h0, {31'h0, ioPinOe[12]});
    wrap_up();
  end
endmodule // tb_multichannel_timer_clock_select
